// ===== bench/gdc_pwm_source.sv
// gdc_pwm_source: timer pwm outputs and the protection, current limit and comparator event levels facing the block
// assumes the bench sets the wanted levels; every line changes just after a pclk edge
`timescale 1ns/1ps
module gdc_pwm_source (
  input  wire logic        pclk,
  input  wire logic [6:0]  set_pwm,
  input  wire logic [10:0] set_ev,
  output logic      [6:0]  timer_pwm_out,
  output logic      [10:0] events
);
  logic tog = 1'b0;
  // output 3 reaches no driver: it toggles so that any use of it shows
  always_ff @(posedge pclk) begin
    tog           <= ~tog;
    timer_pwm_out <= {set_pwm[6:4], tog, set_pwm[2:0]};
    events        <= set_ev;
  end
endmodule

// ===== bench/tb.sv
// tb: self-checking bench for the gate drive control block
// assumes the pwm source model of gdc_pwm_source.sv on the pwm and event inputs
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sv = 1'b0;
  logic [7:0]  paddr = 8'h00, sw = 8'h00, got;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, busy, mclk, mdat, pirq, cirq, irq, pc;
  logic [6:0]  set_pwm = 7'h00, pwm;
  logic [10:0] set_ev = 11'h000, ev;
  logic [2:0]  lo, hi;
  int          errors = 0, comparisons = 0, n, gap, both, nb;

  always #2 pclk = ~pclk;

  gdc_pwm_source gdc_pwm_source_i (.pclk(pclk), .set_pwm(set_pwm), .set_ev(set_ev),
    .timer_pwm_out(pwm), .events(ev));

  gdc_gate_drive_control gdc_gate_drive_control_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pwm_out(pwm),
    .protection_event(ev[0]), .current_limit_event(ev[1]),
    .fast_protect_comparator(ev[2]), .slow_protect_comparator(ev[3]), .back_emf(ev[4]),
    .special_comparator(ev[5]), .phase_comparator(ev[6]), .analog_io_pin(ev[10:7]),
    .seq_mux_valid(sv), .seq_mux_word(sw), .seq_mux_busy(busy), .mux_link_clock(mclk),
    .mux_link_data(mdat), .low_side_drive(lo), .high_side_drive(hi),
    .protect_irq(pirq), .comparator_irq(cirq), .irq(irq));

  task results;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // one apb transfer; waits for pready, only the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("read data", x, r);
    chk("slave error", {31'h0, xe}, {31'h0, e});
  endtask

  task pw(input logic [6:0] v);
    set_pwm <= v;
    cyc(4);
  endtask

  task drv(input logic [2:0] el, input logic [2:0] eh);
    chk("low drive", {29'h0, el}, {29'h0, lo});
    chk("high drive", {29'h0, eh}, {29'h0, hi});
  endtask

  initial begin
    cyc(20000);
    errors++;
    results();
  end

  initial begin
    cyc(12);
    presetn <= 1'b1;
    rd(gdc_pkg::ADDR_CTRL, 32'h10, 1'b0);
    rd(gdc_pkg::ADDR_DEADTIME, 32'h04, 1'b0);
    rd(gdc_pkg::ADDR_PWM_PERIOD, 32'h100, 1'b0);
    rd(gdc_pkg::ADDR_IRQ_EN, 32'h0, 1'b0);
    wr(gdc_pkg::ADDR_STATUS, 32'hFF);
    rd(gdc_pkg::ADDR_STATUS, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    $display("test registers done");
    pw(7'h77);
    drv(3'h0, 3'h0);
    wr(gdc_pkg::ADDR_CTRL, 32'h01);
    for (int k = 0; k < 3; k++) begin
      pw(7'h01 << k);
      drv(3'h1 << k, 3'h0);
      pw(7'h10 << k);
      drv(3'h0, 3'h1 << k);
    end
    wr(gdc_pkg::ADDR_CTRL, 32'h11);
    pw(7'h77);
    drv(3'h0, 3'h0);
    $display("test routing done");
    wr(gdc_pkg::ADDR_CTRL, 32'h05);
    set_ev <= 11'h001;
    cyc(3);
    drv(3'h0, 3'h7);
    cyc(8);
    drv(3'h0, 3'h7);
    wr(gdc_pkg::ADDR_CTRL, 32'h09);
    cyc(2);
    drv(3'h7, 3'h0);
    wr(gdc_pkg::ADDR_CTRL, 32'h0D);
    cyc(2);
    drv(3'h0, 3'h0);
    set_ev <= 11'h000;
    cyc(4);
    drv(3'h7, 3'h7);
    $display("test protection done");
    wr(gdc_pkg::ADDR_CTRL, 32'h03);
    for (int dt = 2; dt < 8; dt += 4) begin
      wr(gdc_pkg::ADDR_DEADTIME, dt);
      pw(7'h00);
      cyc(dt + 4);
      drv(3'h7, 3'h0);
      set_pwm <= 7'h70;
      gap = 0;
      both = 0;
      repeat (dt + 12) begin
        @(posedge pclk);
        if (lo[0] === 1'b0 && hi[0] === 1'b0) gap++;
        if (lo[0] === 1'b1 && hi[0] === 1'b1) both++;
      end
      chk("dead gap", 1, gap >= dt && gap <= dt + 2);
      chk("overlap", 0, both);
      drv(3'h0, 3'h7);
    end
    $display("test dead time done");
    wr(gdc_pkg::ADDR_PWM_PERIOD, 32'h20);
    wr(gdc_pkg::ADDR_CTRL, 32'h21);
    pw(7'h10);
    drv(3'h0, 3'h1);
    set_ev <= 11'h002;
    @(posedge pclk);
    set_ev <= 11'h000;
    cyc(3);
    drv(3'h0, 3'h0);
    n = 0;
    while (hi[0] !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    chk("limit resumes", 1, n <= 36);
    $display("test current limit done");
    wr(gdc_pkg::ADDR_CTRL, 32'h00);
    wr(gdc_pkg::ADDR_IRQ_CLR, 32'hFF);
    for (int i = 2; i < 11; i++) begin
      set_ev <= 11'h001 << i;
      cyc(3);
      chk("protect irq", i < 4, pirq);
      chk("comparator irq", i >= 4, cirq);
      set_ev <= 11'h000;
      cyc(3);
      chk("irq lines idle", 0, {pirq, cirq});
    end
    rd(gdc_pkg::ADDR_STATUS, 32'hFC, 1'b0);
    chk("irq", 0, irq);
    wr(gdc_pkg::ADDR_IRQ_EN, 32'h04);
    cyc(2);
    chk("irq", 1, irq);
    wr(gdc_pkg::ADDR_IRQ_CLR, 32'h04);
    cyc(2);
    chk("irq", 0, irq);
    rd(gdc_pkg::ADDR_STATUS, 32'hF8, 1'b0);
    $display("test interrupts done");
    for (int j = 0; j < 2; j++) begin
      sv <= 1'b1;
      sw <= j ? 8'h3C : 8'hA5;
      @(posedge pclk);
      sv <= 1'b0;
      got = 8'h00;
      nb = 0;
      pc = 1'b0;
      repeat (40) begin
        @(posedge pclk);
        if (mclk === 1'b1 && pc === 1'b0) begin
          got = {got[6:0], mdat};
          nb++;
        end
        pc = mclk;
      end
      chk("mux word", j ? 8'h3C : 8'hA5, got);
      chk("mux bits", 8, nb);
      chk("mux idle", 0, {busy, mclk});
    end
    $display("test mux link done");
    results();
  end
endmodule

// ===== include/gdc_pkg.sv
// gdc_pkg: register map, field positions and reset values of the gate drive control block
// assumes a 32-bit apb slave with word-aligned registers
package gdc_pkg;
  localparam int unsigned NUM_PHASE      = 3;
  localparam int unsigned DT_WIDTH       = 8;
  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_DEADTIME  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_EN    = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_CLR   = 8'h10;
  localparam logic [7:0]  ADDR_PWM_PERIOD = 8'h14;
  // control fields
  localparam int unsigned CTRL_UNIT_EN   = 0;
  localparam int unsigned CTRL_DTG_EN    = 1;
  localparam int unsigned CTRL_MASK_LOW  = 2;
  localparam int unsigned CTRL_MASK_HIGH = 3;
  localparam int unsigned CTRL_BBM_EN    = 4;
  localparam int unsigned CTRL_CBC_EN    = 5;
  localparam int unsigned CTRL_WIDTH     = 6;
  // status / interrupt fields
  localparam int unsigned ST_PROTECT     = 0;
  localparam int unsigned ST_CURLIM      = 1;
  localparam int unsigned ST_FAST        = 2;
  localparam int unsigned ST_SLOW        = 3;
  localparam int unsigned ST_BACK_EMF        = 4;
  localparam int unsigned ST_SPECIAL     = 5;
  localparam int unsigned ST_PHASE       = 6;
  localparam int unsigned ST_AIO         = 7;
  localparam int unsigned ST_WIDTH       = 8;
  // reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET     = 6'h10;
  localparam logic [DT_WIDTH-1:0]   DEADTIME_RESET = 8'h04;
  localparam logic [ST_WIDTH-1:0]   IRQ_EN_RESET   = 8'h00;
  localparam logic [15:0]           PERIOD_RESET   = 16'h0100;
endpackage

// ===== logic/gdc_gate_drive_control.sv
// gdc_gate_drive_control: routes timer pwm to three half-bridge gate driver pairs
// assumes pwm, protection and comparator inputs are synchronous to pclk
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module gdc_gate_drive_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  timer_pwm_out,
  input  wire logic        protection_event,
  input  wire logic        current_limit_event,
  input  wire logic        fast_protect_comparator,
  input  wire logic        slow_protect_comparator,
  input  wire logic        back_emf,
  input  wire logic        special_comparator,
  input  wire logic        phase_comparator,
  input  wire logic [3:0]  analog_io_pin,
  input  wire logic        seq_mux_valid,
  input  wire logic [7:0]  seq_mux_word,
  output logic             seq_mux_busy,
  output logic             mux_link_clock,
  output logic             mux_link_data,
  output logic [2:0]       low_side_drive,
  output logic [2:0]       high_side_drive,
  output logic             protect_irq,
  output logic             comparator_irq,
  output logic             irq
);
  localparam int unsigned NP = gdc_pkg::NUM_PHASE;

  logic [gdc_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [gdc_pkg::DT_WIDTH-1:0]   dead_time;
  logic [15:0]                    pwm_period;
  logic [gdc_pkg::ST_WIDTH-1:0]   status;
  logic [gdc_pkg::ST_WIDTH-1:0]   irq_en;
  logic [15:0]                    period_cnt;
  logic                           curlim_latch;
  logic [NP-1:0]                  dt_high;
  logic [NP-1:0]                  dt_low;
  logic [NP-1:0]                  next_low;
  logic [NP-1:0]                  next_high;
  logic [NP-1:0]                  cmd_high;
  logic [NP-1:0]                  cmd_low;
  logic                           unit_en;
  logic                           gate_low;
  logic                           gate_high;
  logic                           wr_en;
  logic                           rd_en;
  logic [gdc_pkg::ST_WIDTH-1:0]   events;
  logic [gdc_pkg::ST_WIDTH-1:0]   clr;
  logic [31:0]                    next_rdata;
  logic                           map_hit;

  assign unit_en = ctrl[gdc_pkg::CTRL_UNIT_EN];
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;

  // apb slave: one wait-free access phase, pready registered high in access
  always_comb begin
    map_hit    = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      gdc_pkg::ADDR_CTRL:       next_rdata[gdc_pkg::CTRL_WIDTH-1:0] = ctrl;
      gdc_pkg::ADDR_DEADTIME:   next_rdata[gdc_pkg::DT_WIDTH-1:0] = dead_time;
      gdc_pkg::ADDR_STATUS:     next_rdata[gdc_pkg::ST_WIDTH-1:0] = status;
      gdc_pkg::ADDR_IRQ_EN:     next_rdata[gdc_pkg::ST_WIDTH-1:0] = irq_en;
      gdc_pkg::ADDR_IRQ_CLR:    next_rdata = 32'h0000_0000;
      gdc_pkg::ADDR_PWM_PERIOD: next_rdata[15:0] = pwm_period;
      default:                  map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      if (rd_en) begin
        prdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= gdc_pkg::CTRL_RESET;
      dead_time  <= gdc_pkg::DEADTIME_RESET;
      irq_en     <= gdc_pkg::IRQ_EN_RESET;
      pwm_period <= gdc_pkg::PERIOD_RESET;
    end else if (wr_en && pready) begin
      case (paddr)
        gdc_pkg::ADDR_CTRL:       ctrl <= pwdata[gdc_pkg::CTRL_WIDTH-1:0];
        gdc_pkg::ADDR_DEADTIME:   dead_time <= pwdata[gdc_pkg::DT_WIDTH-1:0];
        gdc_pkg::ADDR_IRQ_EN:     irq_en <= pwdata[gdc_pkg::ST_WIDTH-1:0];
        gdc_pkg::ADDR_PWM_PERIOD: pwm_period <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // sticky status: a new event wins over a same-cycle clear
  assign clr = (wr_en && pready && paddr == gdc_pkg::ADDR_IRQ_CLR) ?
               pwdata[gdc_pkg::ST_WIDTH-1:0] : '0;
  assign events = {|analog_io_pin, phase_comparator, special_comparator, back_emf,
                   slow_protect_comparator, fast_protect_comparator,
                   current_limit_event, protection_event};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq            <= 1'b0;
      protect_irq    <= 1'b0;
      comparator_irq <= 1'b0;
    end else begin
      irq            <= |((status & ~clr | events) & irq_en);
      protect_irq    <= fast_protect_comparator | slow_protect_comparator;
      comparator_irq <= back_emf | special_comparator | phase_comparator
                        | (|analog_io_pin);
    end
  end

  // pwm period counter; a current limit event blanks drive until wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt   <= 16'h0000;
      curlim_latch <= 1'b0;
    end else begin
      if (period_cnt >= pwm_period) begin
        period_cnt   <= 16'h0000;
        // an event on the wrap edge still blanks the new period
        curlim_latch <= current_limit_event & ctrl[gdc_pkg::CTRL_CBC_EN];
      end else begin
        period_cnt <= period_cnt + 16'h0001;
        if (current_limit_event && ctrl[gdc_pkg::CTRL_CBC_EN]) begin
          curlim_latch <= 1'b1;
        end
      end
    end
  end

  // group gating: masked protection acts in the cycle it is seen
  assign gate_low  = protection_event & ctrl[gdc_pkg::CTRL_MASK_LOW];
  assign gate_high = protection_event & ctrl[gdc_pkg::CTRL_MASK_HIGH];

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_phase
      gdc_dead_time u_dt (
        .pclk      (pclk),
        .presetn   (presetn),
        .pwm_in    (timer_pwm_out[g+4]),
        .dead_time (dead_time),
        .high_out  (dt_high[g]),
        .low_out   (dt_low[g])
      );
    end
  endgenerate

  always_comb begin
    for (int unsigned p = 0; p < NP; p++) begin
      if (ctrl[gdc_pkg::CTRL_DTG_EN]) begin
        cmd_high[p] = dt_high[p];
        cmd_low[p]  = dt_low[p];
      end else begin
        cmd_high[p] = timer_pwm_out[p+4];
        cmd_low[p]  = timer_pwm_out[p];
      end
      next_high[p] = unit_en & cmd_high[p] & ~gate_high & ~curlim_latch;
      next_low[p]  = unit_en & cmd_low[p] & ~gate_low & ~curlim_latch;
      if (ctrl[gdc_pkg::CTRL_BBM_EN] && next_high[p] && next_low[p]) begin
        next_high[p] = 1'b0;
        next_low[p]  = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_side_drive  <= '0;
      high_side_drive <= '0;
    end else begin
      low_side_drive  <= next_low;
      high_side_drive <= next_high;
    end
  end

  // write-only mux link: eight bits msb first, clock high in first half of a bit
  logic [7:0] mux_shift;
  logic [3:0] mux_bits;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_shift      <= 8'h00;
      mux_bits       <= 4'h0;
      seq_mux_busy   <= 1'b0;
      mux_link_clock <= 1'b0;
      mux_link_data  <= 1'b0;
    end else if (!seq_mux_busy) begin
      mux_link_clock <= 1'b0;
      if (seq_mux_valid) begin
        mux_shift     <= seq_mux_word;
        mux_bits      <= 4'h8;
        seq_mux_busy  <= 1'b1;
      end
    end else if (!mux_link_clock) begin
      if (mux_bits == 4'h0) begin
        seq_mux_busy  <= 1'b0;
        mux_link_data <= 1'b0;
      end else begin
        mux_link_data  <= mux_shift[7];
        mux_link_clock <= 1'b1;
        mux_shift      <= {mux_shift[6:0], 1'b0};
        mux_bits       <= mux_bits - 4'h1;
      end
    end else begin
      mux_link_clock <= 1'b0;
    end
  end

  property p_disabled_low;
    @(posedge pclk) disable iff (!presetn)
      !unit_en |=> (low_side_drive == 3'h0 && high_side_drive == 3'h0);
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("drive on while disabled");

  property p_protect_low;
    @(posedge pclk) disable iff (!presetn)
      gate_low |=> low_side_drive == 3'h0;
  endproperty
  a_protect_low: assert property (p_protect_low) else $error("low group not gated");

  property p_protect_high;
    @(posedge pclk) disable iff (!presetn)
      gate_high |=> high_side_drive == 3'h0;
  endproperty
  a_protect_high: assert property (p_protect_high) else $error("high group not gated");

  property p_direct_route;
    @(posedge pclk) disable iff (!presetn)
      (unit_en && !ctrl[gdc_pkg::CTRL_DTG_EN] && !protection_event && !curlim_latch
       && !ctrl[gdc_pkg::CTRL_BBM_EN])
      |=> high_side_drive == $past(timer_pwm_out[6:4])
          && low_side_drive == $past(timer_pwm_out[2:0]);
  endproperty
  a_direct_route: assert property (p_direct_route) else $error("direct routing wrong");

  property p_bbm;
    @(posedge pclk) disable iff (!presetn)
      ctrl[gdc_pkg::CTRL_BBM_EN] |=> (low_side_drive & high_side_drive) == 3'h0;
  endproperty
  a_bbm: assert property (p_bbm) else $error("both sides on");

  property p_dtg_compl;
    @(posedge pclk) disable iff (!presetn)
      ctrl[gdc_pkg::CTRL_DTG_EN] |=> (low_side_drive & high_side_drive) == 3'h0;
  endproperty
  a_dtg_compl: assert property (p_dtg_compl) else $error("dead time overlap");

  property p_curlim;
    @(posedge pclk) disable iff (!presetn)
      curlim_latch |=> low_side_drive == 3'h0 && high_side_drive == 3'h0;
  endproperty
  a_curlim: assert property (p_curlim) else $error("drive during current limit");

  property p_protect_irq;
    @(posedge pclk) disable iff (!presetn)
      (fast_protect_comparator || slow_protect_comparator) |=> protect_irq;
  endproperty
  a_protect_irq: assert property (p_protect_irq) else $error("protect irq missing");

  property p_comp_irq;
    @(posedge pclk) disable iff (!presetn)
      (back_emf || special_comparator || phase_comparator || (|analog_io_pin))
      |=> comparator_irq;
  endproperty
  a_comp_irq: assert property (p_comp_irq) else $error("comparator irq missing");

  c_dtg_on: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl[gdc_pkg::CTRL_DTG_EN] && high_side_drive[0] ##[1:300] low_side_drive[0]);
  c_protect: cover property (@(posedge pclk) disable iff (!presetn) gate_low && gate_high);
  c_curlim: cover property (@(posedge pclk) disable iff (!presetn) $rose(curlim_latch));
endmodule

// complementary pair with programmable dead time; both sides low while counting
module gdc_dead_time (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         pwm_in,
  input  wire logic [gdc_pkg::DT_WIDTH-1:0] dead_time,
  output logic                              high_out,
  output logic                              low_out
);
  logic                         last;
  logic [gdc_pkg::DT_WIDTH-1:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last     <= 1'b0;
      cnt      <= '0;
      high_out <= 1'b0;
      low_out  <= 1'b0;
    end else begin
      last <= pwm_in;
      if (pwm_in != last) begin
        cnt      <= dead_time;
        high_out <= 1'b0;
        low_out  <= 1'b0;
      end else if (cnt != '0) begin
        cnt <= cnt - 8'h01;
      end else begin
        high_out <= pwm_in;
        low_out  <= ~pwm_in;
      end
    end
  end
endmodule
